// File: pkg/cbfm_pkg.sv
/*
 package of the bus fault manager: register offsets, field positions, timing figures and carriers.
 assumes a 25 MHz sys_clk; analog comparators sit outside and arrive as digital levels.
*/
`default_nettype none
package cbfm_pkg;
    localparam int unsigned CLK_MHZ          = 25;
    // timing figures in their own unit, then cycle counts
    localparam int unsigned SAMPLE_WIN_NS    = 1000;
    localparam int unsigned SAMPLE_WIN_CYC   = SAMPLE_WIN_NS * CLK_MHZ / 1000;
    localparam int unsigned TX_STUCK_US      = 750;
    localparam int unsigned TX_STUCK_CYC     = TX_STUCK_US * CLK_MHZ;
    localparam int unsigned TX_REL_US        = 32;
    localparam int unsigned TX_REL_CYC       = TX_REL_US * CLK_MHZ + 1;
    localparam int unsigned WAKE_FILT_US     = 16;
    localparam int unsigned WAKE_FILT_CYC    = WAKE_FILT_US * CLK_MHZ;
    localparam int unsigned FAULT_FILT_US    = 30;
    localparam int unsigned FAULT_FILT_CYC   = FAULT_FILT_US * CLK_MHZ;
    localparam int unsigned CNT_W            = 17;
    localparam logic [2:0]  OPEN_LIMIT       = 3'h4;
    localparam logic [2:0]  OPEN_ZERO        = 3'h0;
    // register indices (3-bit address, 4-bit data)
    localparam logic [2:0]  ADDR_MODE        = 3'h0;
    localparam logic [2:0]  ADDR_RESET_CTRL  = 3'h1;
    localparam logic [2:0]  ADDR_CAN_CTRL    = 3'h2;
    localparam logic [2:0]  ADDR_IO_CTRL     = 3'h3;
    localparam logic [2:0]  ADDR_FAULT_STAT  = 3'h4;
    // field positions
    localparam int unsigned RCR_WAKE_BIT     = 0;
    localparam int unsigned RCR_TXSTUCK_BIT  = 1;
    localparam int unsigned IOR_SHIFT_BIT    = 2;
    localparam int unsigned VAR_SEL_BIT      = 2;
    localparam logic [3:0]  DATA_ZERO        = 4'h0;
    localparam logic [1:0]  SHIFT_SEL_RST    = 2'h0;

    typedef enum logic [1:0] {CM_TXRX, CM_RXONLY, CM_BATTERY_TERMINATION_MODE} cbfm_can_mode_t;
    typedef enum logic [1:0] {SM_NORMAL, SM_STANDBY, SM_STOP, SM_SLEEP} cbfm_sbc_mode_t;
    typedef enum logic [1:0] {OW_IDLE, OW_WAIT, OW_EVAL} cbfm_ow_state_t;

    // digital comparator outputs from the bus front end
    typedef struct packed {
        logic diff_dom;
        logic high_se_dom;
        logic low_se_dom;
        logic high_wake_dom;
        logic low_wake_dom;
        logic high_to_5v;
        logic high_to_bat;
        logic low_to_gnd;
        logic low_to_high;
        logic low_to_bat;
        logic low_to_5v;
        logic high_to_gnd;
        logic high_below_shift;
    } cbfm_cmp_t;

    // driver and termination switches
    typedef struct packed {
        logic high_drv_en;
        logic low_drv_en;
        logic high_term_on;
        logic low_term_on;
    } cbfm_sw_t;
endpackage
`default_nettype wire

// File: verilog/cbfm_top.sv
/*
 bus fault manager of a fault-tolerant low-speed CAN transceiver: fault classification and
 driver/termination switching, open-wire counting, stuck-dominant transmit guard, battery-termination
 bus activity report, wake handling and ground-shift capture, with a small register port.
 assumes comparator levels arrive asynchronously and the mode state machine lives elsewhere.
*/
// Our own choices: the address map and the strobed register port.
// Functional notes
// - fault checking runs only in transmit-receive or receive-only mode
// - vanished faults restore all switches, through filtered detect and recover delays
// - no fault: both drivers on in transmit-receive mode only, both terminations on, receive follows differential
// - high wire to 5 V or battery: high driver, termination off; receive from low wire
// - low wire to ground, high or battery: low driver, termination off; receive from high
// - low wire to 5 V keeps default operation
// - open wires and high wire to ground change nothing; diagnostics only
// - single-ended receivers sampled within 1 us after differential switching
// - count mismatches; flag open wire when counter reaches 4
// - open-wire counting only while receiving, never while transmitting
// - first variant: after flag, only decrement on dominant samples; recover at zero
// - second variant: dominant decrements, recessive increments to 4; recover at zero
// - transmit low beyond timeout disables the bus driver
// - stuck-dominant status sits at bit 1 of reset control register
// - stuck condition clears after transmit recessive for over 32 us
// - second variant, battery termination, normal or standby: receive shows delayed dominant
// - activity report comes from the wake comparators on both wires
// - wake activity in normal or standby leaves the wake flag clear
// - wake while asleep requests normal-request mode and sets wake flag
// - wake in stop mode pulses interrupt and sets wake flag
// - ground shift with four selectable thresholds, result in I/O register
// - ground shift sampled at each transmit falling edge, unfiltered
// - transmit low means dominant, high means recessive
`default_nettype none
module cbfm_top
    import cbfm_pkg::*;
#(
    parameter int unsigned TX_STUCK_CYCLES = TX_STUCK_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       tx_in,
    input  wire cbfm_cmp_t  cmp_in,
    input  wire logic [2:0] reg_addr,
    input  wire logic [3:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output cbfm_sw_t        sw_out,
    output logic            rx_out,
    output logic [1:0]      shift_sel,
    output logic            wake_int,
    output logic            normal_req,
    output logic [3:0]      reg_rdata
);
    // two-stage synchronisers; first stage read only by second
    logic        tx_s1_reg, tx_s2_reg;
    cbfm_cmp_t   cmp_s1_reg, cmp_s2_reg;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_s1_reg  <= 1'b1;
            tx_s2_reg  <= 1'b1;
            cmp_s1_reg <= '0;
            cmp_s2_reg <= '0;
        end else begin
            tx_s1_reg  <= tx_in;
            tx_s2_reg  <= tx_s1_reg;
            cmp_s1_reg <= cmp_in;
            cmp_s2_reg <= cmp_s1_reg;
        end
    end

    // state registers
    cbfm_can_mode_t can_mode_reg, can_mode_next;
    cbfm_sbc_mode_t sbc_mode_reg, sbc_mode_next;
    logic           variant2_reg, variant2_next;
    logic [1:0]     shift_sel_reg, shift_sel_next;
    logic           shift_flag_reg, shift_flag_next;
    logic           wake_flag_reg, wake_flag_next;
    logic           tx_prev_reg, tx_prev_next;
    logic           tx_stuck_reg, tx_stuck_next;
    logic [CNT_W-1:0] tx_cnt_reg, tx_cnt_next;
    logic [3:0]     flt_reg, flt_next;
    logic [CNT_W-1:0] flt_cnt_reg [4];
    logic [CNT_W-1:0] flt_cnt_next [4];
    logic           diff_prev_reg, diff_prev_next;
    cbfm_ow_state_t ow_state_reg, ow_state_next;
    logic [4:0]     win_cnt_reg, win_cnt_next;
    logic           win_hi_reg, win_hi_next, win_lo_reg, win_lo_next;
    logic [2:0]     ow_cnt_reg, ow_cnt_next;
    logic           ow_flag_reg, ow_flag_next;
    logic           ow_high_reg, ow_high_next;
    logic [CNT_W-1:0] wk_cnt_reg, wk_cnt_next;
    logic           wake_busy_reg, wake_busy_next;
    logic           wake_ev_reg, wake_ev_next;
    cbfm_sw_t       sw_reg, sw_next;
    logic           rx_reg, rx_next;
    logic           int_reg, int_next;
    logic           nreq_reg, nreq_next;
    logic [3:0]     rdata_reg, rdata_next;

    logic active, wake_dom, tx_dom, fh, fl;
    logic [3:0] raw;

    always_comb begin
        can_mode_next  = can_mode_reg;
        sbc_mode_next  = sbc_mode_reg;
        variant2_next  = variant2_reg;
        shift_sel_next = shift_sel_reg;
        shift_flag_next = shift_flag_reg;
        wake_flag_next = wake_flag_reg;
        tx_cnt_next    = tx_cnt_reg;
        tx_stuck_next  = tx_stuck_reg;
        flt_next       = flt_reg;
        flt_cnt_next   = flt_cnt_reg;
        ow_state_next  = ow_state_reg;
        win_cnt_next   = win_cnt_reg;
        win_hi_next    = win_hi_reg;
        win_lo_next    = win_lo_reg;
        ow_cnt_next    = ow_cnt_reg;
        ow_flag_next   = ow_flag_reg;
        ow_high_next   = ow_high_reg;
        wk_cnt_next    = wk_cnt_reg;
        wake_busy_next = wake_busy_reg;
        wake_ev_next   = 1'b0;
        int_next       = 1'b0;
        nreq_next      = 1'b0;
        rdata_next     = DATA_ZERO;
        tx_dom         = ~tx_s2_reg;
        tx_prev_next   = tx_s2_reg;
        diff_prev_next = cmp_s2_reg.diff_dom;
        active         = (can_mode_reg == CM_TXRX) || (can_mode_reg == CM_RXONLY);

        // fault classes: 0 high to 5 V, 1 high to battery, 2 low to gnd/high, 3 low to battery
        raw = {cmp_s2_reg.low_to_bat, cmp_s2_reg.low_to_gnd | cmp_s2_reg.low_to_high,
               cmp_s2_reg.high_to_bat, cmp_s2_reg.high_to_5v};
        // low to 5 V and high to ground are not classed: default operation
        for (int i = 0; i < 4; i++) begin
            if (!active) begin
                flt_next[i]     = 1'b0;
                flt_cnt_next[i] = '0;
            end else if (raw[i] != flt_reg[i]) begin
                // same filter for detect and recover keeps it symmetric
                if (flt_cnt_reg[i] >= CNT_W'(FAULT_FILT_CYC - 1)) begin
                    flt_next[i]     = raw[i];
                    flt_cnt_next[i] = '0;
                end else begin
                    flt_cnt_next[i] = flt_cnt_reg[i] + 1'b1;
                end
            end else begin
                flt_cnt_next[i] = '0;
            end
        end
        fh = flt_reg[0] | flt_reg[1];
        fl = flt_reg[2] | flt_reg[3];

        // stuck-dominant transmit guard
        if (tx_dom) begin
            if (!tx_stuck_reg && tx_cnt_reg >= CNT_W'(TX_STUCK_CYCLES - 1)) begin
                tx_stuck_next = 1'b1;
                tx_cnt_next   = '0;
            end else if (!tx_stuck_reg) begin
                tx_cnt_next = tx_cnt_reg + 1'b1;
            end else begin
                tx_cnt_next = '0;
            end
        end else if (tx_stuck_reg) begin
            if (tx_cnt_reg >= CNT_W'(TX_REL_CYC - 1)) begin
                tx_stuck_next = 1'b0;
                tx_cnt_next   = '0;
            end else begin
                tx_cnt_next = tx_cnt_reg + 1'b1;
            end
        end else begin
            tx_cnt_next = '0;
        end

        // ground shift: high wire sampled on transmit falling edge, no filter
        if (tx_prev_reg && !tx_s2_reg && cmp_s2_reg.high_below_shift)
            shift_flag_next = 1'b1;

        // open-wire sampling window after each recessive-to-dominant differential switch, receiving only
        case (ow_state_reg)
            OW_IDLE: begin
                // only the dominant switch is sampled: on a recessive edge both wires idle alike
                if (active && !tx_dom && cmp_s2_reg.diff_dom && !diff_prev_reg) begin
                    ow_state_next = OW_WAIT;
                    win_cnt_next  = '0;
                    win_hi_next   = 1'b0;
                    win_lo_next   = 1'b0;
                end
            end
            OW_WAIT: begin
                // a dominant single-ended sample inside the window counts as a toggle
                win_hi_next  = win_hi_reg | cmp_s2_reg.high_se_dom;
                win_lo_next  = win_lo_reg | cmp_s2_reg.low_se_dom;
                win_cnt_next = win_cnt_reg + 1'b1;
                if (tx_dom)
                    ow_state_next = OW_IDLE;
                else if (win_cnt_reg >= 5'(SAMPLE_WIN_CYC - 1))
                    ow_state_next = OW_EVAL;
            end
            OW_EVAL: begin
                ow_state_next = OW_IDLE;
                if (!ow_flag_reg) begin
                    if (!win_hi_reg || !win_lo_reg) begin
                        ow_cnt_next  = ow_cnt_reg + 1'b1;
                        ow_high_next = !win_hi_reg;
                        if (ow_cnt_reg == OPEN_LIMIT - 3'h1)
                            ow_flag_next = 1'b1;
                    end
                end else if (ow_high_reg ? win_hi_reg : win_lo_reg) begin
                    // recovery sample on the formerly silent wire
                    ow_cnt_next = ow_cnt_reg - 1'b1;
                    if (ow_cnt_reg == OPEN_ZERO + 3'h1)
                        ow_flag_next = 1'b0;
                end else if (variant2_reg && ow_cnt_reg != OPEN_LIMIT) begin
                    ow_cnt_next = ow_cnt_reg + 1'b1;
                end
            end
            default: ow_state_next = OW_IDLE;
        endcase
        if (!active) begin
            ow_state_next = OW_IDLE;
        end

        // battery-termination activity: both wake comparators, filtered by the wake time
        wake_dom = cmp_s2_reg.high_wake_dom | cmp_s2_reg.low_wake_dom;
        if (can_mode_reg == CM_BATTERY_TERMINATION_MODE && wake_dom) begin
            if (!wake_busy_reg && wk_cnt_reg >= CNT_W'(WAKE_FILT_CYC - 1)) begin
                wake_busy_next = 1'b1;
                wake_ev_next   = 1'b1;
            end else if (!wake_busy_reg) begin
                wk_cnt_next = wk_cnt_reg + 1'b1;
            end
        end else begin
            wk_cnt_next    = '0;
            wake_busy_next = 1'b0;
        end
        if (wake_ev_reg) begin
            case (sbc_mode_reg)
                SM_SLEEP: begin
                    nreq_next      = 1'b1;
                    wake_flag_next = 1'b1;
                end
                SM_STOP: begin
                    int_next       = 1'b1;
                    wake_flag_next = 1'b1;
                end
                default: ;
            endcase
        end

        // switch and receive path
        sw_next.high_drv_en  = !fh && !tx_stuck_reg && can_mode_reg == CM_TXRX;
        sw_next.low_drv_en   = !fl && !tx_stuck_reg && can_mode_reg == CM_TXRX;
        sw_next.high_term_on = !fh;
        sw_next.low_term_on  = !fl;
        if (can_mode_reg == CM_BATTERY_TERMINATION_MODE)
            // receive stays low only while the filtered activity lasts
            rx_next = !(variant2_reg && wake_busy_reg &&
                        (sbc_mode_reg == SM_NORMAL || sbc_mode_reg == SM_STANDBY));
        else if (fh)
            rx_next = !cmp_s2_reg.low_se_dom;
        else if (fl)
            rx_next = !cmp_s2_reg.high_se_dom;
        else
            rx_next = !cmp_s2_reg.diff_dom;

        // register port; reading status clears the sticky flags, a new event wins
        if (reg_wr) begin
            case (reg_addr)
                ADDR_MODE:     sbc_mode_next  = cbfm_sbc_mode_t'(reg_wdata[1:0]);
                ADDR_CAN_CTRL: begin
                    can_mode_next = (reg_wdata[1:0] == 2'h3) ? CM_BATTERY_TERMINATION_MODE : cbfm_can_mode_t'(reg_wdata[1:0]);
                    variant2_next = reg_wdata[VAR_SEL_BIT];
                end
                ADDR_IO_CTRL:  shift_sel_next = reg_wdata[1:0];
                default: ;
            endcase
        end
        if (sbc_mode_reg == SM_STOP || sbc_mode_reg == SM_SLEEP)
            can_mode_next = CM_BATTERY_TERMINATION_MODE;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_MODE:       rdata_next = {2'h0, sbc_mode_reg};
                ADDR_RESET_CTRL: begin
                    rdata_next[RCR_WAKE_BIT]    = wake_flag_reg;
                    rdata_next[RCR_TXSTUCK_BIT] = tx_stuck_reg;
                    if (!(wake_ev_reg && (sbc_mode_reg == SM_STOP || sbc_mode_reg == SM_SLEEP)))
                        wake_flag_next = 1'b0;
                end
                ADDR_CAN_CTRL:   rdata_next = flt_reg;
                ADDR_IO_CTRL: begin
                    rdata_next[1:0]           = shift_sel_reg;
                    rdata_next[IOR_SHIFT_BIT] = shift_flag_reg;
                    if (!(tx_prev_reg && !tx_s2_reg && cmp_s2_reg.high_below_shift))
                        shift_flag_next = 1'b0;
                end
                ADDR_FAULT_STAT: rdata_next = {ow_high_reg, ow_flag_reg,
                                               cmp_s2_reg.low_to_5v, cmp_s2_reg.high_to_gnd};
                default:         rdata_next = DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            can_mode_reg   <= CM_BATTERY_TERMINATION_MODE;
            sbc_mode_reg   <= SM_NORMAL;
            variant2_reg   <= 1'b1;
            shift_sel_reg  <= SHIFT_SEL_RST;
            shift_flag_reg <= 1'b0;
            wake_flag_reg  <= 1'b0;
            tx_prev_reg    <= 1'b1;
            tx_stuck_reg   <= 1'b0;
            tx_cnt_reg     <= '0;
            flt_reg        <= '0;
            for (int i = 0; i < 4; i++) flt_cnt_reg[i] <= '0;
            diff_prev_reg  <= 1'b0;
            ow_state_reg   <= OW_IDLE;
            win_cnt_reg    <= '0;
            win_hi_reg     <= 1'b0;
            win_lo_reg     <= 1'b0;
            ow_cnt_reg     <= OPEN_ZERO;
            ow_flag_reg    <= 1'b0;
            ow_high_reg    <= 1'b0;
            wk_cnt_reg     <= '0;
            wake_busy_reg  <= 1'b0;
            wake_ev_reg    <= 1'b0;
            sw_reg         <= '0;
            rx_reg         <= 1'b1;
            int_reg        <= 1'b0;
            nreq_reg       <= 1'b0;
            rdata_reg      <= DATA_ZERO;
        end else begin
            can_mode_reg   <= can_mode_next;
            sbc_mode_reg   <= sbc_mode_next;
            variant2_reg   <= variant2_next;
            shift_sel_reg  <= shift_sel_next;
            shift_flag_reg <= shift_flag_next;
            wake_flag_reg  <= wake_flag_next;
            tx_prev_reg    <= tx_prev_next;
            tx_stuck_reg   <= tx_stuck_next;
            tx_cnt_reg     <= tx_cnt_next;
            flt_reg        <= flt_next;
            flt_cnt_reg    <= flt_cnt_next;
            diff_prev_reg  <= diff_prev_next;
            ow_state_reg   <= ow_state_next;
            win_cnt_reg    <= win_cnt_next;
            win_hi_reg     <= win_hi_next;
            win_lo_reg     <= win_lo_next;
            ow_cnt_reg     <= ow_cnt_next;
            ow_flag_reg    <= ow_flag_next;
            ow_high_reg    <= ow_high_next;
            wk_cnt_reg     <= wk_cnt_next;
            wake_busy_reg  <= wake_busy_next;
            wake_ev_reg    <= wake_ev_next;
            sw_reg         <= sw_next;
            rx_reg         <= rx_next;
            int_reg        <= int_next;
            nreq_reg       <= nreq_next;
            rdata_reg      <= rdata_next;
        end
    end

    assign sw_out     = sw_reg;
    assign rx_out     = rx_reg;
    assign shift_sel  = shift_sel_reg;
    assign wake_int   = int_reg;
    assign normal_req = nreq_reg;
    assign reg_rdata  = rdata_reg;
endmodule
`default_nettype wire

// File: verification/cbfm_checker.sv
/* port checker of the bus fault manager.
 assumes cbfm_top and its package; bound at the foot of this file. */
`default_nettype none
module cbfm_checker
    import cbfm_pkg::*;
#(
    parameter int unsigned TX_STUCK_CYCLES = TX_STUCK_CYC
) (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       tx_in,
    input wire cbfm_cmp_t  cmp_in,
    input wire logic [2:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire cbfm_sw_t   sw_out,
    input wire logic       rx_out,
    input wire logic [1:0] shift_sel,
    input wire logic       wake_int,
    input wire logic       normal_req,
    input wire logic [3:0] reg_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    int low_run_reg;
    int low_run_next;
    // saturates so a long stuck spell cannot wrap back to zero
    always_comb low_run_next = tx_in ? 0 : (low_run_reg > 100000 ? low_run_reg : low_run_reg + 1);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) low_run_reg <= 0;
        else low_run_reg <= low_run_next;
    end
    sequence io_write;
        reg_wr && reg_addr == ADDR_IO_CTRL;
    endsequence
    sequence far_read;
        reg_rd && reg_addr > ADDR_FAULT_STAT;
    endsequence
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == DATA_ZERO)
        else $error("read data outside a read slot");
    unmapped_zero_a: assert property (far_read |=> reg_rdata == DATA_ZERO)
        else $error("unmapped read not zero");
    shift_write_a: assert property (io_write |=> shift_sel == $past(reg_wdata[1:0]))
        else $error("threshold select not taken");
    wake_pulse_a: assert property (wake_int |=> !wake_int)
        else $error("interrupt pulse too long");
    req_pulse_a: assert property (normal_req |=> !normal_req)
        else $error("mode request pulse too long");
    one_event_a: assert property (!(wake_int && normal_req))
        else $error("both wake events at once");
    high_pair_a: assert property (!sw_out.high_term_on |-> !sw_out.high_drv_en)
        else $error("high driver on without termination");
    low_pair_a: assert property (!sw_out.low_term_on |-> !sw_out.low_drv_en)
        else $error("low driver on without termination");
    stuck_off_a: assert property (low_run_reg > TX_STUCK_CYCLES + 4 |-> sw_out[3:2] == 2'h0)
        else $error("drivers on during stuck transmit");
endmodule
bind cbfm_top cbfm_checker #(.TX_STUCK_CYCLES(TX_STUCK_CYCLES)) u_chk (.sys_clk(sys_clk), .rstn(rstn),
    .tx_in(tx_in), .cmp_in(cmp_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .sw_out(sw_out), .rx_out(rx_out), .shift_sel(shift_sel), .wake_int(wake_int),
    .normal_req(normal_req), .reg_rdata(reg_rdata));
`default_nettype wire

// File: verification/cbfm_host_model.sv
/* protocol controller at the transmit and receive pins.
 assumes the bench commands dominant spells; one clock. */
`default_nettype none
module cbfm_host_model (
    input  wire logic sys_clk,
    input  wire logic force_dom,
    input  wire logic rx_in,
    output logic      tx_out,
    output int        rx_low_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        tx_out = 1'b1;
        rx_low_cnt = 0;
    end
    // low on the pin is dominant, so idle is high
    always @(posedge sys_clk) begin
        tx_out <= !force_dom;
        if (rx_in === 1'b0) rx_low_cnt <= rx_low_cnt + 1;
    end
endmodule
`default_nettype wire

// File: verification/test_can_bus_fault_manager.sv
/* self-checking bench of the bus fault manager.
 assumes the package, the bound checker and the host model. */
`default_nettype none
module test_can_bus_fault_manager
    import cbfm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned STUCK = 50;
    logic       sys_clk, rstn, reg_wr, reg_rd, tx_in, rx_out, wake_int, normal_req, force_dom;
    logic [2:0] reg_addr;
    logic [3:0] reg_wdata, reg_rdata, d;
    logic [1:0] shift_sel, sel;
    cbfm_cmp_t  cmp_in;
    cbfm_sw_t   sw_out;
    int         error_cnt, comparisons, n_int, n_req, c0, rx_low;
    int         q[$] = '{7, 6, 5, 4, 3, 2, 1};
    logic [3:0] flt_exp [8] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h4, 4'h4, 4'h2, 4'h1};
    cbfm_top #(.TX_STUCK_CYCLES(STUCK)) dut (.sys_clk(sys_clk), .rstn(rstn), .tx_in(tx_in), .cmp_in(cmp_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .sw_out(sw_out),
        .rx_out(rx_out), .shift_sel(shift_sel), .wake_int(wake_int), .normal_req(normal_req), .reg_rdata(reg_rdata));
    cbfm_host_model host (.sys_clk(sys_clk), .force_dom(force_dom), .rx_in(rx_out), .tx_out(tx_in),
        .rx_low_cnt(rx_low));
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(logic [2:0] a, logic [3:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [2:0] a, output logic [3:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // high-wire faults drop the high side, low-wire faults the low side; the rest change nothing
    function automatic logic [3:0] exp_sw(int i);
        return (i >= 6) ? 4'h5 : (i >= 3) ? 4'ha : 4'hf;
    endfunction
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (wake_int === 1'b1) n_int <= n_int + 1;
        if (normal_req === 1'b1) n_req <= n_req + 1;
    end
    // every filter wait added up stays well below this
    initial begin
        #(40 * 60000);
        error_cnt++;
        end_sim();
    end
    initial begin
        {rstn, reg_wr, reg_rd, force_dom, reg_addr, reg_wdata} = '0;
        {cmp_in, error_cnt, comparisons, n_int, n_req} = '0;
        void'($urandom(32'h06392716));
        tick(5);
        rstn <= 1'b1;
        wr(ADDR_CAN_CTRL, 4'h4);
        cmp_in.diff_dom <= 1'b1;
        tick(10);
        chk("sw_clean", sw_out, 4'hf);
        chk("rx_diff", rx_out, 1'b0);
        foreach (q[k]) begin
            cmp_in[q[k]] <= 1'b1;
            tick(800);
            chk("sw_fault", sw_out, exp_sw(q[k]));
            chk("rx_fault", rx_out, exp_sw(q[k]) != 4'hf);
            rd(ADDR_CAN_CTRL, d);
            chk("flt_stat", d, flt_exp[q[k]]);
            cmp_in[q[k]] <= 1'b0;
            tick(800);
            chk("sw_back", sw_out, 4'hf);
        end
        $display("test faults done");
        for (int ph = 0; ph < 2; ph++) begin
            // first variant must recover on dominant samples alone
            if (ph == 1) wr(ADDR_CAN_CTRL, 4'h0);
            for (int p = 0; p < 16; p++) begin
                cmp_in.diff_dom <= p[0];
                cmp_in.low_se_dom <= p[0];
                cmp_in.high_se_dom <= p[0] && ph == 1;
                tick(40);
            end
            rd(ADDR_FAULT_STAT, d);
            chk("open_flag", d[2], ph == 0);
        end
        rd(3'h5 + 3'($urandom_range(2)), d);
        chk("unmapped", d, DATA_ZERO);
        $display("test open wire done");
        force_dom <= 1'b1;
        tick(STUCK + 10);
        chk("drv_stuck", sw_out[3:2], 2'h0);
        rd(ADDR_RESET_CTRL, d);
        chk("stuck_bit", d[RCR_TXSTUCK_BIT], 1'b1);
        force_dom <= 1'b0;
        tick(TX_REL_CYC + 10);
        chk("drv_back", sw_out, 4'hf);
        rd(ADDR_RESET_CTRL, d);
        chk("stuck_clr", d[RCR_TXSTUCK_BIT], 1'b0);
        $display("test stuck transmit done");
        sel = 2'($urandom);
        wr(ADDR_IO_CTRL, {2'h0, sel});
        cmp_in.high_below_shift <= 1'b1;
        force_dom <= 1'b1;
        tick(4);
        chk("shift_sel", shift_sel, sel);
        force_dom <= 1'b0;
        tick(6);
        rd(ADDR_IO_CTRL, d);
        chk("shift_hit", d[2:0], {1'b1, sel});
        rd(ADDR_IO_CTRL, d);
        chk("shift_clr", d[IOR_SHIFT_BIT], 1'b0);
        cmp_in.high_below_shift <= 1'b0;
        $display("test ground shift done");
        wr(ADDR_CAN_CTRL, 4'h6);
        tick(2);
        for (int w = 8; w < 10; w++) begin
            c0 = rx_low;
            cmp_in[w] <= 1'b1;
            tick(1000);
            cmp_in[w] <= 1'b0;
            tick(20);
            chk("rx_activity", (rx_low - c0) inside {[598:602]}, 1'b1);
        end
        rd(ADDR_RESET_CTRL, d);
        chk("wake_quiet", {d[RCR_WAKE_BIT], 8'(n_int), 8'(n_req)}, 17'h0);
        $display("test activity done");
        for (int m = 3; m > 1; m--) begin
            wr(ADDR_MODE, 4'(m));
            c0 = n_int + 2 * n_req;
            cmp_in.low_wake_dom <= 1'b1;
            tick(500);
            cmp_in.low_wake_dom <= 1'b0;
            tick(10);
            chk("wake_event", n_int + 2 * n_req - c0, (m == 3) ? 2 : 1);
            rd(ADDR_RESET_CTRL, d);
            chk("wake_flag", d[RCR_WAKE_BIT], 1'b1);
        end
        $display("test wake done");
        end_sim();
    end
endmodule
`default_nettype wire
